/* hdl/cafid_filter.sv */
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// R1 - eleven stored standard id bits must equal received
// R2 - type enable and select one: extended only
// R3 - type enable one, select zero: standard only
// R4 - two stored high extended bits must equal
// R5 - bits four and two read zero, stateless
// R6 - sixteen filter id entries, each read/write
// R7 - match needs all compared bits and type
module cafid_filter
    import cafid_pkg::*;
#(
    parameter int unsigned NUM_FILTERS = CAFID_NUM_FILTERS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // received identifier from the frame receiver, same clock
    input wire cafid_rx_id_t rxId,
    input wire logic rxIdValid,
    // mask-excluded bits from the mask logic: 1 means do not compare
    input wire logic [12:0] compareExclude,
    output logic [15:0] filterHit,
    output logic filterHitValid
);

    // the address decode serves exactly sixteen entries
    if (NUM_FILTERS != CAFID_NUM_FILTERS) begin : gBadCount
        $error("cafid_filter: map holds exactly sixteen filters");
    end

    ////////////////////////////////////////////////////////////////////////
    // storage: contents come up unknown, only control state is reset
    // only the fourteen implemented bits are flops; the view adds the dead bits
    logic [13:0] entryReg [NUM_FILTERS];
    logic [15:0] filterView [NUM_FILTERS];
    logic [15:0] filterEnableReg, filterEnableNext;
    logic [15:0] maskTypeReg, maskTypeNext;
    logic [15:0] filterHitReg, filterHitNext;
    logic hitValidReg, hitValidNext;

    // write channel: take address and data in either order
    logic [7:0] awAddrReg, awAddrNext;
    logic awHeldReg, awHeldNext;
    logic [31:0] wDataReg, wDataNext;
    logic [3:0] wStrbReg, wStrbNext;
    logic wHeldReg, wHeldNext;
    logic bValidReg, bValidNext;
    logic [1:0] bRespReg, bRespNext;
    logic doWrite;
    logic [3:0] wrIndex;
    logic wrFilter;

    assign s_axi_awready = ~awHeldReg & ~bValidReg;
    assign s_axi_wready = ~wHeldReg & ~bValidReg;
    assign s_axi_bvalid = bValidReg;
    assign s_axi_bresp = bRespReg;
    assign doWrite = clkEn & awHeldReg & wHeldReg & ~bValidReg;
    assign wrIndex = awAddrReg[5:2];
    assign wrFilter = (awAddrReg[7:6] == 2'b00); // word offsets 0x00..0x3C

    always_comb begin
        awAddrNext = awAddrReg;
        awHeldNext = awHeldReg;
        wDataNext = wDataReg;
        wStrbNext = wStrbReg;
        wHeldNext = wHeldReg;
        bValidNext = bValidReg;
        bRespNext = bRespReg;
        filterEnableNext = filterEnableReg;
        maskTypeNext = maskTypeReg;
        if (s_axi_awvalid && s_axi_awready) begin
            awAddrNext = s_axi_awaddr;
            awHeldNext = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wDataNext = s_axi_wdata;
            wStrbNext = s_axi_wstrb;
            wHeldNext = 1'b1;
        end
        if (doWrite) begin
            awHeldNext = 1'b0;
            wHeldNext = 1'b0;
            bValidNext = 1'b1;
            bRespNext = CAFID_RESP_OKAY;
            if (awAddrReg == CAFID_CTRL_OFFS) begin
                if (wStrbReg[0]) filterEnableNext[7:0] = wDataReg[7:0];
                if (wStrbReg[1]) filterEnableNext[15:8] = wDataReg[15:8];
            end else if (awAddrReg == CAFID_MASKTYPE_OFFS) begin
                if (wStrbReg[0]) maskTypeNext[7:0] = wDataReg[7:0];
                if (wStrbReg[1]) maskTypeNext[15:8] = wDataReg[15:8];
            end else if (!(wrFilter && awAddrReg[1:0] == 2'b00)
                         && awAddrReg != CAFID_STATUS_OFFS) begin
                bRespNext = CAFID_RESP_SLVERR; // unmapped
            end
        end
        if (bValidReg && s_axi_bready) begin
            bValidNext = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awAddrReg <= 8'h00;
            awHeldReg <= 1'b0;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            wHeldReg <= 1'b0;
            bValidReg <= 1'b0;
            bRespReg <= CAFID_RESP_OKAY;
            filterEnableReg <= CAFID_FILTER_ENABLE_RESET;
            maskTypeReg <= CAFID_MASKTYPE_RESET;
        end else if (clkEn) begin
            awAddrReg <= awAddrNext;
            awHeldReg <= awHeldNext;
            wDataReg <= wDataNext;
            wStrbReg <= wStrbNext;
            wHeldReg <= wHeldNext;
            bValidReg <= bValidNext;
            bRespReg <= bRespNext;
            filterEnableReg <= filterEnableNext;
            maskTypeReg <= maskTypeNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-entry storage and comparison
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FILTERS; gi++) begin : gFilter
            logic [15:0] stored;
            logic stdOk, extOk, typeOk;
            // bits 4 and 2 never written, so never hold state
            always_ff @(posedge clk) begin
                if (doWrite && wrFilter && awAddrReg[1:0] == 2'b00
                    && wrIndex == 4'(gi)) begin // see R6
                    if (wStrbReg[0]) begin
                        entryReg[gi][5:3] <= wDataReg[7:5];
                        entryReg[gi][2] <= wDataReg[3];
                        entryReg[gi][1:0] <= wDataReg[1:0];
                    end
                    if (wStrbReg[1]) entryReg[gi][13:6] <= wDataReg[15:8];
                end
            end
            // dead bits are wired zero, so no write can ever reach them
            assign filterView[gi] = {entryReg[gi][13:3], 1'b0, entryReg[gi][2], 1'b0,
                                     entryReg[gi][1:0]}; // see R5
            assign stored = filterView[gi];
            // excluded bits count as matching
            assign stdOk = &(~(stored[CAFID_STD_MSB:CAFID_STD_LSB] ^ rxId.stdIdBits)
                             | compareExclude[12:2]); // see R1
            assign extOk = &(~(stored[CAFID_EXT_HI_MSB:CAFID_EXT_HI_LSB]
                               ^ rxId.extIdHighBits) | compareExclude[1:0]); // see R4
            // select bit only counts when the type enable is set
            assign typeOk = ~maskTypeReg[gi]
                            | (stored[CAFID_EXT_SEL_BIT] == rxId.isExtended); // see R2 R3
            assign filterHitNext[gi] = filterEnableReg[gi] & stdOk & extOk & typeOk; // see R7
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registered match result, one cycle after the identifier
    assign hitValidNext = rxIdValid;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filterHitReg <= 16'h0000;
            hitValidReg <= 1'b0;
        end else if (clkEn) begin
            filterHitReg <= rxIdValid ? filterHitNext : filterHitReg;
            hitValidReg <= hitValidNext;
        end
    end
    assign filterHit = filterHitReg;
    assign filterHitValid = hitValidReg;

    ////////////////////////////////////////////////////////////////////////
    // read channel: data registered, one outstanding read
    cafid_rd_state_t rdState, rdStateNext;
    logic [31:0] rDataReg, rDataNext;
    logic [1:0] rRespReg, rRespNext;

    assign s_axi_arready = (rdState == CAFID_RD_IDLE);
    assign s_axi_rvalid = (rdState == CAFID_RD_RESP);
    assign s_axi_rdata = rDataReg;
    assign s_axi_rresp = rRespReg;

    always_comb begin
        rdStateNext = rdState;
        rDataNext = rDataReg;
        rRespNext = rRespReg;
        case (rdState)
            CAFID_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rdStateNext = CAFID_RD_RESP;
                    rRespNext = CAFID_RESP_OKAY;
                    rDataNext = 32'h0000_0000;
                    if (s_axi_araddr[7:6] == 2'b00 && s_axi_araddr[1:0] == 2'b00) begin
                        rDataNext[15:0] = filterView[s_axi_araddr[5:2]]; // see R5
                    end else if (s_axi_araddr == CAFID_CTRL_OFFS) begin
                        rDataNext[15:0] = filterEnableReg;
                    end else if (s_axi_araddr == CAFID_STATUS_OFFS) begin
                        rDataNext[15:0] = filterHitReg;
                    end else if (s_axi_araddr == CAFID_MASKTYPE_OFFS) begin
                        rDataNext[15:0] = maskTypeReg;
                    end else begin
                        rRespNext = CAFID_RESP_SLVERR;
                    end
                end
            end
            CAFID_RD_RESP: begin
                if (s_axi_rready) rdStateNext = CAFID_RD_IDLE;
            end
            default: rdStateNext = CAFID_RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdState <= CAFID_RD_IDLE;
            rDataReg <= 32'h0000_0000;
            rRespReg <= CAFID_RESP_OKAY;
        end else if (clkEn) begin
            rdState <= rdStateNext;
            rDataReg <= rDataNext;
            rRespReg <= rRespNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    std_mismatch_a: assert property ( // see R1
        clkEn && rxIdValid && compareExclude == 13'h0000
        && filterView[0][15:5] != rxId.stdIdBits |=> !filterHit[0])
        else $error("filter 0 hit despite std id mismatch");
    ext_only_a: assert property ( // see R2
        clkEn && rxIdValid && maskTypeReg[0]
        && filterView[0][3] && !rxId.isExtended |=> !filterHit[0])
        else $error("extended-only filter hit standard frame");
    std_only_a: assert property ( // see R3
        clkEn && rxIdValid && maskTypeReg[0]
        && !filterView[0][3] && rxId.isExtended |=> !filterHit[0])
        else $error("standard-only filter hit extended frame");
    ext_high_a: assert property ( // see R4
        clkEn && rxIdValid && compareExclude == 13'h0000
        && filterView[1][1:0] != rxId.extIdHighBits |=> !filterHit[1])
        else $error("filter 1 hit despite extended bits mismatch");
    // only filter entries have dead bits; control words use every low bit
    zero_bits_a: assert property ( // see R5
        clkEn && s_axi_arvalid && s_axi_arready && s_axi_araddr[7:6] == 2'b00
        |=> s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0
        && s_axi_rdata[31:16] == 16'h0000)
        else $error("reserved read bits not zero");
    read_latency_a: assert property ( // see R6
        clkEn && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle later");
    all_excluded_a: assert property ( // see R7
        clkEn && rxIdValid && compareExclude == 13'h1FFF
        && !maskTypeReg[2] && filterEnableReg[2] |=> filterHit[2])
        else $error("fully masked enabled filter did not hit");
    disabled_a: assert property ( // see R7
        clkEn && rxIdValid && !filterEnableReg[3] |=> !filterHit[3])
        else $error("disabled filter hit");

    hit_seen_c: cover property (filterHitValid && filterHit != 16'h0000);
    write_seen_c: cover property (s_axi_bvalid && s_axi_bready);
    read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
    ext_frame_c: cover property (clkEn && rxIdValid && rxId.isExtended && maskTypeReg != 16'h0000);

endmodule

/* hdl/cafid_pkg.sv */
package cafid_pkg;
    localparam int unsigned CAFID_NUM_FILTERS = 16;
    localparam int unsigned CAFID_STD_ID_W = 11;
    localparam int unsigned CAFID_EXT_HI_W = 2;
    // field positions inside the 16-bit filter identifier word
    localparam int unsigned CAFID_STD_LSB = 5;
    localparam int unsigned CAFID_STD_MSB = 15;
    localparam int unsigned CAFID_EXT_SEL_BIT = 3;
    localparam int unsigned CAFID_EXT_HI_LSB = 0;
    localparam int unsigned CAFID_EXT_HI_MSB = 1;
    // register map: filters at word offsets 0..15, control/status above them
    localparam logic [7:0] CAFID_FILTER_BASE = 8'h00;
    localparam logic [7:0] CAFID_CTRL_OFFS = 8'h40;
    localparam logic [7:0] CAFID_STATUS_OFFS = 8'h44;
    localparam logic [7:0] CAFID_MASKTYPE_OFFS = 8'h48;
    localparam logic [15:0] CAFID_MASKTYPE_RESET = 16'h0000;
    localparam logic [15:0] CAFID_FILTER_ENABLE_RESET = 16'h0000;
    localparam logic [1:0] CAFID_RESP_OKAY = 2'h0;
    localparam logic [1:0] CAFID_RESP_SLVERR = 2'h2;

    // received identifier as presented by the frame receiver
    typedef struct packed {
        logic [10:0] stdIdBits;
        logic [1:0] extIdHighBits;
        logic isExtended;
    } cafid_rx_id_t;

    typedef enum logic [2:0] {
        CAFID_RD_IDLE = 3'b001,
        CAFID_RD_RESP = 3'b010,
        CAFID_RD_HOLD = 3'b100
    } cafid_rd_state_t;
endpackage

/* tb/cafid_rx_node.sv */
`timescale 1ns/1ps
// frame receiver stand-in: presents one received identifier per call
module cafid_rx_node
    import cafid_pkg::*;
(
    output cafid_rx_id_t rxId,
    output logic rxIdValid,
    input wire logic clk
);
    initial begin
        rxId = '0;
        rxIdValid = 1'b0;
    end
    // one-cycle strobe; lines go inverted after it so a stale id never passes
    task automatic send(input logic [10:0] s, input logic [1:0] e, input logic x);
        @(posedge clk);
        rxId <= '{s, e, x};
        rxIdValid <= 1'b1;
        @(posedge clk);
        rxId <= cafid_rx_id_t'(~{s, e, x});
        rxIdValid <= 1'b0;
    endtask
endmodule

/* tb/can_rx_acceptance_filter_id_tb_top.sv */
`timescale 1ns/1ps
module can_rx_acceptance_filter_id_tb_top
    import cafid_pkg::*;
;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic clkEn = 1'b1;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, hitValid;
    logic [1:0] bresp, rresp, resp;
    logic [12:0] excl = '0;
    logic [15:0] hit;
    logic [31:0] rd;
    cafid_rx_id_t rxId;
    logic rxIdValid;
    int n_mismatch = 0;
    int total_checks = 0;
    ////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 clk = ~clk;
    cafid_filter dut_u (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxId(rxId),
        .rxIdValid(rxIdValid), .compareExclude(excl), .filterHit(hit),
        .filterHitValid(hitValid));
    cafid_rx_node node_u (.rxId(rxId), .rxIdValid(rxIdValid), .clk(clk));
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        n_mismatch++;
        $display("MISMATCH %0t no answer", $time);
        test_done();
    endtask
    // handshakes are judged at the falling edge, acted on at the next rise
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar, r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clk);
            ar = arvalid && arready;
            r = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (r) begin
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    // one received id through the node, hit vector judged in its valid cycle
    task automatic chk_id(input logic [10:0] s, input logic [1:0] e, input logic x,
                          input logic [12:0] ex, input logic [15:0] exp);
        @(posedge clk);
        excl <= ex;
        node_u.send(s, e, x);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            if (hitValid === 1'b1) begin
                cmp({16'h0000, hit}, {16'h0000, exp});
                return;
            end
        end
        hang();
    endtask
    function automatic logic [15:0] fw(input int n);
        logic [10:0] s;
        s = (n < 2) ? 11'h123 : 11'(32'h200 + n);
        return {s, 1'b0, (n == 1) || (n > 1 && n[0]), 1'b0, (n < 2) ? 2'h2 : n[1:0]};
    endfunction
    ////////////////////////////////////////////////////////////////
    // all sixteen entries; dead and upper bits written as ones must read zero
    task automatic test_entries();
        axi_wr(CAFID_CTRL_OFFS, 32'h0000_FFFF);
        axi_wr(CAFID_MASKTYPE_OFFS, 32'h0000_0003);
        for (int n = 0; n < 16; n++) begin
            axi_wr(8'(4 * n), 32'hFFFF_0014 | {16'h0000, fw(n)});
            cmp({30'h0, resp}, {30'h0, CAFID_RESP_OKAY});
            axi_rd(8'(4 * n));
            cmp(rd, {16'h0000, fw(n)});
        end
    endtask
    // identifier bits and type select with the type check on for 0 and 1
    task automatic test_match();
        chk_id(11'h123, 2'h2, 1'b0, 13'h0000, 16'h0001);
        chk_id(11'h123, 2'h2, 1'b1, 13'h0000, 16'h0002);
        chk_id(11'h123, 2'h3, 1'b0, 13'h0000, 16'h0000);
        chk_id(11'h123, 2'h3, 1'b0, 13'h0001, 16'h0001);
        chk_id(11'h122, 2'h2, 1'b0, 13'h0000, 16'h0000);
        chk_id(11'h122, 2'h2, 1'b0, 13'h0004, 16'h0001);
        axi_rd(CAFID_STATUS_OFFS);
        cmp(rd, 32'h0000_0001);
    endtask
    // type check off for filter 1: its select bit must be ignored
    task automatic test_type_off();
        axi_wr(CAFID_MASKTYPE_OFFS, 32'h0000_0001);
        chk_id(11'h123, 2'h2, 1'b0, 13'h0000, 16'h0003);
    endtask
    // filters 0 and 3 disabled; a fully excluded id hits every other one
    task automatic test_disable();
        axi_wr(CAFID_CTRL_OFFS, 32'h0000_FFF6);
        chk_id(11'h123, 2'h2, 1'b0, 13'h0000, 16'h0002);
        chk_id(11'h7FF, 2'h0, 1'b1, 13'h1FFF, 16'hFFF6);
    endtask
    // clock enable low: an id that would hit filter 1 must leave no trace
    task automatic test_freeze();
        @(posedge clk);
        clkEn <= 1'b0;
        node_u.send(11'h123, 2'h2, 1'b0);
        @(negedge clk);
        cmp({15'h0000, hitValid, hit}, {15'h0000, 1'b0, 16'hFFF6});
        @(posedge clk);
        clkEn <= 1'b1;
    endtask
    // unmapped word: error response both ways, read data zero
    task automatic test_unmapped();
        axi_wr(8'h80, 32'h0000_FFFF);
        cmp({30'h0, resp}, {30'h0, CAFID_RESP_SLVERR});
        axi_rd(8'h80);
        cmp(rd, 32'h0000_0000);
        cmp({30'h0, resp}, {30'h0, CAFID_RESP_SLVERR});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        sysRst <= 1'b0;
        test_entries();
        test_match();
        test_type_off();
        test_disable();
        test_freeze();
        test_unmapped();
        test_done();
    end
    // overall limit on the run
    initial begin
        #2000000;
        hang();
    end
endmodule
